//--- rtl/cprc_pkg.sv
// constants for the clock, power and reset control block
`default_nettype none
package cprc_pkg;
  // machine cycle: six states of two phases, one phase per halved clock
  localparam int unsigned CPRC_STATES = 6;
  localparam int unsigned CPRC_PHASES_PER_MC = 12;
  localparam logic [3:0] CPRC_PHASE_LAST = 4'hb;
  // state five phase two, counted from zero
  localparam logic [3:0] CPRC_PHASE_STATE_FIVE_PHASE_TWO = 4'h9;
  // reset accepted after this many consecutive high samples
  localparam logic [1:0] CPRC_RST_SAMPLES = 2'h2;
  // power control register layout
  localparam int unsigned CPRC_POWER_CONTROL_REGISTER_IDLE = 0;
  localparam int unsigned CPRC_POWER_CONTROL_REGISTER_PD = 1;
  localparam int unsigned CPRC_POWER_CONTROL_REGISTER_GF0 = 2;
  localparam int unsigned CPRC_POWER_CONTROL_REGISTER_GF1 = 3;
  localparam int unsigned CPRC_POWER_CONTROL_REGISTER_COLD = 4;
  localparam logic [7:0] CPRC_POWER_CONTROL_REGISTER_RST = 8'h00;
  localparam logic [7:0] CPRC_POWER_CONTROL_REGISTER_WMASK = 8'h1f;
  localparam logic [7:0] CPRC_PORT_RST = 8'hff;
  localparam logic [7:0] CPRC_SP_RST = 8'h07;
  localparam logic [7:0] CPRC_SFR_RST = 8'h00;
  typedef enum logic [1:0] {CPRC_RUN, CPRC_IDLE, CPRC_PDOWN} cprc_mode_t;
endpackage
`default_nettype wire

//--- rtl/cprc_ctrl.sv
// clock division, idle and power-down control, reset filtering and reset values
`timescale 1ns/10ps
`default_nettype none
// Contract
// - divide input clock by two and run internal timing on the halved clock
// - writing one to the idle request bit enters idle mode
// - idle gates processor clock; peripherals and interrupts stay clocked
// - enabled interrupt or reset ends idle and restarts processor clock
// - power-down request stops all clocks and the oscillator
// - power-down is left only by reset; interrupts do not wake it
// - reset input sampled once per machine cycle at state five phase two; the code reads it on every clock in power-down and for release
// - reset input filtered so short glitches cause no reset; in power-down the pin is unfiltered and a glitch wakes the part
// - during reset ports load all ones and stack pointer loads seven
// - reset clears power control except cold boot flag; serial buffer kept
// - cold boot flag set at power-on, cleared only by software write
module cprc_ctrl
  import cprc_pkg::*;
(
  input wire logic i_mclk, // oscillator input clock
  input wire logic i_srst, // power-on reset, synchronous
  input wire logic i_ext_rst, // external reset pin, asynchronous
  input wire logic i_irq, // enabled interrupt pending, same domain
  input wire logic i_power_control_register_we, // power control register write strobe
  input wire logic [7:0] i_power_control_register_wdata, // power control write data
  input wire logic i_serial_buffer_we, // serial buffer write strobe
  input wire logic [7:0] i_serial_buffer_wdata, // serial buffer write data
  output logic o_osc_en, // oscillator enable, low in power-down
  output logic o_phase_en, // halved-clock tick for all internal logic
  output logic o_cpu_clk_en, // processor clock gate
  output logic o_periph_clk_en, // peripheral and interrupt clock gate
  output logic [3:0] o_phase, // phase index within machine cycle
  output logic o_sys_rst, // internal reset, filtered
  output logic [7:0] o_power_control_register, // power control register
  output logic [7:0] o_port_latch, // port latch reset image
  output logic [7:0] o_sp, // stack pointer reset image
  output logic [7:0] o_sfr, // other special registers reset image
  output logic [7:0] o_serial_buffer, // serial buffer, not reset
  output logic [1:0] o_mode // current power mode
);
  // ****************************************
  // input synchronisers
  // ****************************************
  // pin is asynchronous to the oscillator; only rst_sync is read below
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge i_mclk) begin
    rst_meta <= i_ext_rst;
    rst_sync <= rst_meta;
  end

  // ****************************************
  // divide by two and phase counter
  // ****************************************
  logic half;
  logic [3:0] phase;
  cprc_mode_t mode;
  cprc_mode_t next_mode;
  // one decode of the mode register, shared by gating and readback
  wire in_run = (mode == CPRC_RUN);
  wire in_idle = (mode == CPRC_IDLE);
  wire in_pdown = (mode == CPRC_PDOWN);
  wire tick = half & !in_pdown;
  wire mc_end = tick & (phase == CPRC_PHASE_LAST);
  wire sample_pt = tick & (phase == CPRC_PHASE_STATE_FIVE_PHASE_TWO);

  // halved clock only; input duty cycle never reaches timing
  always_ff @(posedge i_mclk) begin
    if (i_srst || in_pdown) begin
      half <= 1'b0;
    end else begin
      half <= ~half;
    end
  end

  // twelve ticks make one machine cycle; the count stalls in power-down
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      phase <= 4'h0;
    end else if (mc_end) begin
      phase <= 4'h0;
    end else if (tick) begin
      phase <= phase + 4'h1;
    end
  end

  // ****************************************
  // reset filter
  // ****************************************
  // a lone high sample is a glitch; two in a row is a real reset
  logic [1:0] rst_cnt;
  logic ext_rst_q;
  wire [1:0] next_rst_cnt = !rst_sync ? 2'h0 :
                            (rst_cnt == CPRC_RST_SAMPLES) ? rst_cnt : rst_cnt + 2'h1;
  // in power-down the phase stalls, so the pin is read unsampled there
  // limitation: no filtering there, so a glitch in power-down also wakes the part
  wire pd_wake = in_pdown & rst_sync;

  // the count saturates, so a long reset stays accepted at every sample
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rst_cnt <= 2'h0;
    end else if (sample_pt) begin
      rst_cnt <= next_rst_cnt;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ext_rst_q <= 1'b0;
    end else if (sample_pt) begin
      // once asserted, stay asserted for as long as the pin is held
      ext_rst_q <= (next_rst_cnt == CPRC_RST_SAMPLES) || (ext_rst_q && rst_sync);
    end else if (pd_wake) begin
      ext_rst_q <= 1'b1;
    end else if (!rst_sync) begin
      ext_rst_q <= 1'b0;
    end
  end

  // power-on and filtered pin reset act alike except on the cold boot flag, divider, phase count and filter, which only power-on resets
  wire sys_rst = i_srst | ext_rst_q;

  // ****************************************
  // power mode
  // ****************************************
  wire pd_req = i_power_control_register_we & i_power_control_register_wdata[CPRC_POWER_CONTROL_REGISTER_PD];
  wire idle_req = i_power_control_register_we & i_power_control_register_wdata[CPRC_POWER_CONTROL_REGISTER_IDLE];

  always_comb begin
    next_mode = mode;
    case (mode)
      CPRC_RUN: begin
        // power-down is tested first, so both bits together mean power-down
        if (pd_req) begin
          next_mode = CPRC_PDOWN;
        end else if (idle_req) begin
          next_mode = CPRC_IDLE;
        end
      end
      CPRC_IDLE: begin
        if (i_irq) begin
          next_mode = CPRC_RUN;
        end
      end
      CPRC_PDOWN: begin
        next_mode = CPRC_PDOWN;
      end
      default: begin
        next_mode = CPRC_RUN;
      end
    endcase
  end

  // any reset lands in run, whatever request was pending
  always_ff @(posedge i_mclk) begin
    if (sys_rst) begin
      mode <= CPRC_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // ****************************************
  // power control and reset images
  // ****************************************
  logic [7:0] power_control_register;
  logic cold;
  // mode bits read back the live mode, so they drop when the mode ends
  wire [7:0] power_control_register_ctl = {4'h0, power_control_register[CPRC_POWER_CONTROL_REGISTER_GF1:CPRC_POWER_CONTROL_REGISTER_GF0],
                         in_pdown, in_idle};

  always_ff @(posedge i_mclk) begin
    if (sys_rst) begin
      power_control_register <= CPRC_POWER_CONTROL_REGISTER_RST;
    end else if (i_power_control_register_we) begin
      power_control_register <= i_power_control_register_wdata & CPRC_POWER_CONTROL_REGISTER_WMASK;
    end
  end

  // power-on and software writes set it; external reset leaves it as software left it
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cold <= 1'b1;
    end else if (i_power_control_register_we) begin
      cold <= i_power_control_register_wdata[CPRC_POWER_CONTROL_REGISTER_COLD];
    end
  end

  // only the reset images live here; normal running holds them
  always_ff @(posedge i_mclk) begin
    if (sys_rst) begin
      o_port_latch <= CPRC_PORT_RST;
      o_sp <= CPRC_SP_RST;
      o_sfr <= CPRC_SFR_RST;
    end else begin
      o_port_latch <= o_port_latch;
      o_sp <= o_sp;
      o_sfr <= o_sfr;
    end
  end

  // serial buffer deliberately has no reset term
  always_ff @(posedge i_mclk) begin
    if (i_serial_buffer_we) begin
      o_serial_buffer <= i_serial_buffer_wdata;
    end
  end

  // ****************************************
  // clock gates and outputs
  // ****************************************
  // oscillator stops with the mode; only a reset, from the pin or power-on, can restart it
  assign o_osc_en = !in_pdown;
  assign o_phase_en = tick;
  assign o_cpu_clk_en = tick & in_run;
  assign o_periph_clk_en = tick;
  assign o_phase = phase;
  assign o_sys_rst = sys_rst;
  assign o_power_control_register = {power_control_register_ctl[7:5], cold, power_control_register_ctl[3:0]};
  assign o_mode = mode;
endmodule
`default_nettype wire

//--- bench/cprc_rst_src.sv
// external reset source model driving the reset pin
`timescale 1ns/10ps
`default_nettype none
module cprc_rst_src (
  input wire logic i_mclk, // oscillator clock, running
  input wire logic i_go, // start one pulse
  input wire logic [7:0] i_len, // pulse length in clocks
  output logic o_ext_rst // reset pin, pull-down when released
);
  logic [7:0] cnt = 8'h00;
  // whole-clock pulses; a legal caller asks for two machine cycles or more
  always @(posedge i_mclk) cnt <= i_go ? i_len : cnt - {7'h0, cnt != 8'h00};
  assign o_ext_rst = cnt != 8'h00;
endmodule
`default_nettype wire

//--- bench/cprc_ctrl_monitor.sv
// port assertions for the clock, power and reset control block
`timescale 1ns/10ps
`default_nettype none
module cprc_ctrl_monitor
  import cprc_pkg::*;
(
  input wire logic i_mclk, // clock
  input wire logic i_srst, // reset
  input wire logic i_ext_rst, // reset pin
  input wire logic [3:0] o_phase, // phase index
  input wire logic i_irq, // wake request
  input wire logic i_power_control_register_we, // write strobe
  input wire logic [7:0] i_power_control_register_wdata, // write data
  input wire logic o_osc_en, // oscillator
  input wire logic o_phase_en, // tick
  input wire logic o_cpu_clk_en, // cpu gate
  input wire logic o_sys_rst, // reset out
  input wire logic [7:0] o_port_latch, // ports
  input wire logic [7:0] o_sp, // stack pointer
  input wire logic [7:0] o_sfr, // others
  input wire logic [1:0] o_mode // mode
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // writes from run only; a pending external reset would mask the effect
  wire logic run_wr = i_power_control_register_we && o_mode == CPRC_RUN && !o_sys_rst;
  osc_off_a: assert property (o_mode == CPRC_PDOWN |-> !o_osc_en) else $error("osc on");
  half_tick_a: assert property (o_phase_en |=> !o_phase_en
    ##1 (o_phase_en || o_sys_rst || o_mode == CPRC_PDOWN)) else $error("tick");
  cpu_gate_a: assert property (o_cpu_clk_en |-> o_phase_en && o_mode == CPRC_RUN)
    else $error("cpu clock");
  idle_in_a: assert property (run_wr && i_power_control_register_wdata[1:0] == 2'h1 |=> o_mode == CPRC_IDLE)
    else $error("idle");
  pd_in_a: assert property (run_wr && i_power_control_register_wdata[1] |=> o_mode == CPRC_PDOWN)
    else $error("pdown");
  irq_wake_a: assert property (o_mode == CPRC_IDLE && i_irq && !o_sys_rst
    |=> o_mode == CPRC_RUN) else $error("wake");
  pd_hold_a: assert property (o_mode == CPRC_PDOWN && !o_sys_rst |=> o_mode == CPRC_PDOWN)
    else $error("pd left");
  rst_load_a: assert property (o_sys_rst |=> o_port_latch == CPRC_PORT_RST
    && o_sp == CPRC_SP_RST && o_sfr == CPRC_SFR_RST) else $error("reset values");
  rst_hold_a: assert property (o_sys_rst && $past(i_ext_rst, 2) |=> o_sys_rst)
    else $error("reset dropped");
  phase_step_a: assert property (o_phase_en |=> o_phase ==
    (($past(o_phase) == CPRC_PHASE_LAST) ? 4'h0 : $past(o_phase) + 4'h1)) else $error("phase");
  cover property (o_mode == CPRC_IDLE ##1 o_mode == CPRC_RUN);
  cover property (o_mode == CPRC_PDOWN ##1 o_sys_rst);
  cover property ($fell(o_sys_rst));
endmodule
bind cprc_ctrl cprc_ctrl_monitor i_cprc_ctrl_monitor (
  .i_mclk(i_mclk),
  .i_srst(i_srst),
  .i_ext_rst(i_ext_rst),
  .o_phase(o_phase),
  .i_irq(i_irq),
  .i_power_control_register_we(i_power_control_register_we),
  .i_power_control_register_wdata(i_power_control_register_wdata),
  .o_osc_en(o_osc_en),
  .o_phase_en(o_phase_en),
  .o_cpu_clk_en(o_cpu_clk_en),
  .o_sys_rst(o_sys_rst),
  .o_port_latch(o_port_latch),
  .o_sp(o_sp),
  .o_sfr(o_sfr),
  .o_mode(o_mode)
);
`default_nettype wire

//--- bench/tb_cprc_ctrl.sv
// randomised self-checking bench for the clock, power and reset control block
`timescale 1ns/10ps
`default_nettype none
module tb_cprc_ctrl
  import cprc_pkg::*;
;
  logic i_mclk = 1'h0, i_srst = 1'h1, i_irq = 1'h0, i_power_control_register_we = 1'h0, i_serial_buffer_we = 1'h0;
  logic go = 1'h0, seen = 1'h0, i_ext_rst, o_osc_en, o_phase_en, o_cpu_clk_en;
  logic o_periph_clk_en, o_sys_rst;
  logic [3:0] o_phase, ph;
  logic [7:0] i_power_control_register_wdata = 8'h00, i_serial_buffer_wdata = 8'h00, len = 8'h00, r;
  logic [7:0] o_power_control_register, o_port_latch, o_sp, o_sfr, o_serial_buffer;
  logic [1:0] o_mode;
  int miscompares = 0, checks_done = 0, seed = 32'h50886877, n;
  always #2 i_mclk = ~i_mclk;
  // go clears the record, so each pin pulse is judged on its own
  always @(posedge i_mclk) seen <= go ? 1'h0 : seen | o_sys_rst;
  cprc_rst_src i_cprc_rst_src (.i_mclk(i_mclk), .i_go(go), .i_len(len), .o_ext_rst(i_ext_rst));
  cprc_ctrl i_cprc_ctrl (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_ext_rst(i_ext_rst),
    .i_irq(i_irq),
    .i_power_control_register_we(i_power_control_register_we),
    .i_power_control_register_wdata(i_power_control_register_wdata),
    .i_serial_buffer_we(i_serial_buffer_we),
    .i_serial_buffer_wdata(i_serial_buffer_wdata),
    .o_osc_en(o_osc_en),
    .o_phase_en(o_phase_en),
    .o_cpu_clk_en(o_cpu_clk_en),
    .o_periph_clk_en(o_periph_clk_en),
    .o_phase(o_phase),
    .o_sys_rst(o_sys_rst),
    .o_power_control_register(o_power_control_register),
    .o_port_latch(o_port_latch),
    .o_sp(o_sp),
    .o_sfr(o_sfr),
    .o_serial_buffer(o_serial_buffer),
    .o_mode(o_mode)
  );
  function automatic logic [7:0] epcon(input logic [7:0] d);
    return {3'h0, d[4:2], d[1], d[0] & ~d[1]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    i_power_control_register_wdata = d;
    i_power_control_register_we = 1'h1;
    @(negedge i_mclk);
    i_power_control_register_we = 1'h0;
    chk("power_control_register", o_power_control_register, epcon(d));
  endtask
  task automatic pin(input logic [7:0] l);
    len = l;
    go = 1'h1;
    @(negedge i_mclk);
    go = 1'h0;
    repeat (l + 8'h40) @(negedge i_mclk);
  endtask
  task automatic summarize;
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // the full sequence needs under a thousand clocks
  initial begin
    repeat (4000) @(posedge i_mclk);
    miscompares++;
    summarize();
  end
  initial begin
    repeat (10) @(negedge i_mclk);
    i_srst = 1'h0;
    chk("reset", {o_power_control_register, o_port_latch, o_sp, o_sfr}, {8'h10, CPRC_PORT_RST, CPRC_SP_RST, CPRC_SFR_RST});
    repeat (3) begin
      r = $random(seed);
      wr({3'h0, 1'h1, r[3:2], 2'h1});
      n = 0;
      repeat (24) @(negedge i_mclk) n += {o_periph_clk_en, o_cpu_clk_en};
      chk("gates", n, 32'h18);
      i_irq = 1'h1;
      @(negedge i_mclk);
      i_irq = 1'h0;
      chk("wake", o_mode, CPRC_RUN);
      ph = o_phase;
      n = 0;
      repeat (24) @(negedge i_mclk) n += {o_periph_clk_en, o_cpu_clk_en};
      chk("run gates", n, CPRC_PHASES_PER_MC * 3);
      chk("phase", o_phase, ph);
    end
    i_serial_buffer_wdata = r;
    i_serial_buffer_we = 1'h1;
    @(negedge i_mclk);
    i_serial_buffer_we = 1'h0;
    wr({3'h0, 1'h0, r[3:2], 2'h0});
    pin(8'h0a);
    chk("glitch", seen, 1'h0);
    pin(8'h48);
    chk("accept", {seen, o_power_control_register, o_serial_buffer}, {1'h1, 8'h00, r});
    for (int k = 2; k < 4; k++) begin
      wr(8'(k));
      i_irq = 1'h1;
      repeat (30) @(negedge i_mclk);
      i_irq = 1'h0;
      chk("pdown", {o_osc_en, o_mode}, {1'h0, CPRC_PDOWN});
      pin(8'h48);
      chk("rerun", o_mode, CPRC_RUN);
    end
    summarize();
  end
endmodule
`default_nettype wire
